// [ulp_defines.svh]
// Purpose: constants for the usb low-power suspend/resume block
// Assumes: 20 MHz mclk, axi4-lite register access
// Notes:   offsets are byte addresses
`ifndef ULP_DEFINES_SVH
`define ULP_DEFINES_SVH
`define ULP_CLK_HZ          20000000
`define ULP_IDLE_TIME_US    3000
`define ULP_IDLE_CYCLES     ((`ULP_IDLE_TIME_US * (`ULP_CLK_HZ / 1000000)))
`define ULP_CNT_W           17
`define ULP_ADDR_W          4
`define ULP_OFF_CTRL        4'h0
`define ULP_OFF_STATUS      4'h4
`define ULP_OFF_MODE        4'h8
`define ULP_BIT_REGEN       2
`define ULP_BIT_PHYEN       0
`define ULP_BIT_RESMEN      5
`define ULP_BIT_IDLE        0
`define ULP_BIT_LPRES       1
`define ULP_BIT_ACTIVE      2
`define ULP_BIT_SUSP        3
`define ULP_RESP_OKAY       2'h0
`define ULP_RESP_SLVERR     2'h2
`define ULP_LS_J            2'h2
`define ULP_LS_K            2'h1
`define ULP_LS_SE0          2'h0
`endif

// [ulp_pkg.sv]
// Purpose: types for the usb low-power suspend/resume block
// Assumes: nothing
// Notes:   none
package ulp_pkg;
  typedef enum logic [1:0] {
    ULP_RUN     = 2'h0,
    ULP_WAIT    = 2'h1,
    ULP_STOP3   = 2'h3,
    ULP_STOP12  = 2'h2
  } ulp_mode_type;
  typedef enum logic [1:0] {
    ULP_S_ACTIVE  = 2'h0,
    ULP_S_SUSPEND = 2'h1,
    ULP_S_ARMED   = 2'h3,
    ULP_S_WOKEN   = 2'h2
  } ulp_state_type;
endpackage

// [ulp_idle_if.sv]
// Purpose: link between top and bus idle timer
// Assumes: one clock
// Notes:   none
interface ulp_idle_if;
  logic bus_idle;
  logic timer_run;
  logic idle_reached;
  modport top (output bus_idle, output timer_run, input idle_reached);
  modport timer (input bus_idle, input timer_run, output idle_reached);
endinterface

// [ulp_idle_timer.sv]
// Purpose: bus idle timer, flags 3 ms of continuous idle
// Assumes: line state synchronous to mclk
// Notes:   restarts on any bus activity
`include "ulp_defines.svh"
module ulp_idle_timer #(
  parameter logic [`ULP_CNT_W-1:0] IDLE_CYCLES = `ULP_CNT_W'(`ULP_IDLE_CYCLES)
) (
  input  wire logic  mclk,
  input  wire logic  rst_b,
  ulp_idle_if.timer  idl
);
  logic [`ULP_CNT_W-1:0] count;
  logic [`ULP_CNT_W-1:0] next_count;
  logic                  reached;
  logic                  next_reached;

  always_comb begin
    next_count = count;
    next_reached = reached;
    if (!idl.bus_idle || !idl.timer_run) begin
      next_count = '0;
      next_reached = 1'b0;
    end else if (count >= IDLE_CYCLES - `ULP_CNT_W'(1)) begin
      next_reached = 1'b1; // R3
    end else begin
      next_count = count + `ULP_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      reached <= 1'b0;
    end else begin
      count <= next_count;
      reached <= next_reached;
    end
  end

  assign idl.idle_reached = reached;
endmodule

// [ulp_suspend_resume.sv]
// Purpose: usb low-power suspend detection and resume wake logic
// Assumes: axi4-lite slave, 20 MHz mclk, line state synchronous
// Notes:   usb clocks are gated off only in stop1/2, or in stop3 while the resume flag is clear
// Summary of operation
// R1: firmware disables regulator and transceiver before stop1 or stop2.
// R2: module stays usable in stop3 to keep resume detection.
// R3: suspend idle flag sets after 3 ms continuous bus idle.
// R4: with resume enable set, a K-state sets the low-power resume flag.
// R5: resume flag raises async wake and re-enables usb module clocks.
// R6: firmware clears resume enable after wake; that write clears the flag.
// R7: in wait mode the module stays fully operational.
// R8: firmware sets resume enable only after idle flag, before stop3.
// R9: firmware keeps the transceiver enabled while bus is suspended.
// R10: transceiver disabled puts both data pins in high impedance.
// R11: after reset resume flag is zero and wake stays inactive.
`include "ulp_defines.svh"
module ulp_suspend_resume (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic [`ULP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`ULP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [1:0]             chip_mode,
  input  wire logic                   usb_dplus_pin_in,
  input  wire logic                   usb_dminus_pin_in,
  output logic                        usb_dplus_pin_oe_b,
  output logic                        usb_dminus_pin_oe_b,
  output logic                        usb_dplus_pin_out,
  output logic                        usb_dminus_pin_out,
  output logic                        usb_voltage_regulator_en,
  output logic                        usb_clock_enable,
  output logic                        async_wake
);
  ulp_idle_if idl ();

  logic                  aw_got;
  logic                  w_got;
  logic [`ULP_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  regen;
  logic                  phyen;
  logic                  resmen;
  logic                  idle_flag;
  logic                  lpres_flag;
  logic                  next_aw_got;
  logic                  next_w_got;
  logic [`ULP_ADDR_W-1:0] next_aw_addr;
  logic [31:0]           next_w_data;
  logic [3:0]            next_w_strb;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_rvalid;
  logic [1:0]            next_rresp;
  logic [31:0]           next_rdata;
  logic                  next_regen;
  logic                  next_phyen;
  logic                  next_resmen;
  logic                  next_idle_flag;
  logic                  next_lpres_flag;
  logic                  next_oe_b;
  logic                  next_clk_en;
  logic                  next_wake;
  logic                  do_write;
  logic                  k_state;
  ulp_pkg::ulp_state_type state;
  ulp_pkg::ulp_state_type next_state;
  ulp_pkg::ulp_mode_type  mode;

  ulp_idle_timer u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .idl   (idl)
  );

  assign mode = ulp_pkg::ulp_mode_type'(chip_mode);
  assign k_state = ({usb_dplus_pin_in, usb_dminus_pin_in} == `ULP_LS_K) && phyen;
  // timer runs in run, wait and stop3 alike
  assign idl.timer_run = phyen && (mode != ulp_pkg::ULP_STOP12); // R2 R7 R1
  assign idl.bus_idle = ({usb_dplus_pin_in, usb_dminus_pin_in} == `ULP_LS_J);
  assign do_write = aw_got && w_got && !s_axi_bvalid;

  // axi4-lite slave
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == `ULP_OFF_CTRL) ? `ULP_RESP_OKAY : `ULP_RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `ULP_RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        `ULP_OFF_CTRL: begin
          next_rdata[`ULP_BIT_RESMEN] = resmen;
          next_rdata[`ULP_BIT_REGEN] = regen;
          next_rdata[`ULP_BIT_PHYEN] = phyen;
        end
        `ULP_OFF_STATUS: begin
          next_rdata[`ULP_BIT_IDLE] = idle_flag;
          next_rdata[`ULP_BIT_LPRES] = lpres_flag;
          next_rdata[`ULP_BIT_ACTIVE] = usb_clock_enable;
          next_rdata[`ULP_BIT_SUSP] = (state != ulp_pkg::ULP_S_ACTIVE);
        end
        `ULP_OFF_MODE: next_rdata[1:0] = chip_mode;
        default: next_rresp = `ULP_RESP_SLVERR;
      endcase
    end
  end

  // control bits, flags and suspend state
  always_comb begin
    next_regen = regen;
    next_phyen = phyen;
    next_resmen = resmen;
    next_idle_flag = idl.idle_reached; // R3
    next_lpres_flag = lpres_flag;
    next_state = state;
    if (do_write && aw_addr == `ULP_OFF_CTRL && w_strb[0]) begin
      next_regen = w_data[`ULP_BIT_REGEN];
      next_phyen = w_data[`ULP_BIT_PHYEN];
      next_resmen = w_data[`ULP_BIT_RESMEN];
    end
    if (!next_resmen) next_lpres_flag = 1'b0; // R6
    if (resmen && next_resmen && k_state) next_lpres_flag = 1'b1; // R4
    case (state)
      ulp_pkg::ULP_S_ACTIVE: if (idl.idle_reached) next_state = ulp_pkg::ULP_S_SUSPEND;
      ulp_pkg::ULP_S_SUSPEND: begin
        if (!idl.bus_idle) next_state = ulp_pkg::ULP_S_ACTIVE;
        else if (resmen) next_state = ulp_pkg::ULP_S_ARMED;
      end
      ulp_pkg::ULP_S_ARMED: begin
        if (lpres_flag) next_state = ulp_pkg::ULP_S_WOKEN;
        else if (!resmen) next_state = ulp_pkg::ULP_S_SUSPEND;
      end
      ulp_pkg::ULP_S_WOKEN: if (!resmen) next_state = ulp_pkg::ULP_S_ACTIVE; // R6
      default: next_state = ulp_pkg::ULP_S_ACTIVE;
    endcase
  end

  // pin enables, wake and clock gating
  always_comb begin
    next_oe_b = !next_phyen; // R10
    next_wake = next_lpres_flag && next_resmen; // R5 R11
    next_clk_en = 1'b1; // R7
    if (mode == ulp_pkg::ULP_STOP12) next_clk_en = 1'b0; // R1
    else if (mode == ulp_pkg::ULP_STOP3 && !next_lpres_flag) next_clk_en = 1'b0; // R2
    if (next_lpres_flag && mode != ulp_pkg::ULP_STOP12) next_clk_en = 1'b1; // R5
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ULP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ULP_RESP_OKAY;
      s_axi_rdata <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      regen <= 1'b0;
      phyen <= 1'b0;
      resmen <= 1'b0;
      idle_flag <= 1'b0;
      lpres_flag <= 1'b0; // R11
      state <= ulp_pkg::ULP_S_ACTIVE;
      usb_dplus_pin_oe_b <= 1'b1;
      usb_dminus_pin_oe_b <= 1'b1;
      usb_voltage_regulator_en <= 1'b0;
      usb_clock_enable <= 1'b1;
      async_wake <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
      s_axi_arready <= !next_rvalid;
      regen <= next_regen;
      phyen <= next_phyen;
      resmen <= next_resmen;
      idle_flag <= next_idle_flag;
      lpres_flag <= next_lpres_flag;
      state <= next_state;
      usb_dplus_pin_oe_b <= next_oe_b;
      usb_dminus_pin_oe_b <= next_oe_b;
      usb_voltage_regulator_en <= next_regen;
      usb_clock_enable <= next_clk_en;
      async_wake <= next_wake;
    end
  end

  // block drives no traffic of its own; the packet engine would
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      usb_dplus_pin_out <= 1'b0;
      usb_dminus_pin_out <= 1'b0;
    end else begin
      usb_dplus_pin_out <= 1'b0;
      usb_dminus_pin_out <= 1'b0;
    end
  end
endmodule

// [ulp_sr_properties.sv]
// Purpose: port checks for the suspend/resume block
// Assumes: one clock, reset active low
// Notes: bound to every instance
module ulp_sr_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  chip_mode,
  input wire logic        usb_dplus_pin_in,
  input wire logic        usb_dminus_pin_in,
  input wire logic        usb_dplus_pin_oe_b,
  input wire logic        usb_dminus_pin_oe_b,
  input wire logic        usb_clock_enable,
  input wire logic        async_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic k_line = !usb_dplus_pin_in && usb_dminus_pin_in;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_pins_hiz_pair: assert property (usb_dplus_pin_oe_b == usb_dminus_pin_oe_b)
    else $error("data pin enables differ");
  a_wake_from_k: assert property ($rose(async_wake) |-> $past(k_line))
    else $error("wake without k state");
  a_wake_clock_on: assert property (async_wake && $past(chip_mode) == 2'h3 |-> usb_clock_enable)
    else $error("wake left clocks off");
  a_stop3_gated: assert property (chip_mode == 2'h3 && $past(chip_mode) == 2'h3 && $past(rst_b)
    && !async_wake |-> !usb_clock_enable)
    else $error("clocks on in armed stop3");
  a_wait_clock_on: assert property (chip_mode == 2'h1 |=> usb_clock_enable)
    else $error("clocks off in wait");
  a_deep_clock_off: assert property (chip_mode == 2'h2 |=> !usb_clock_enable)
    else $error("clocks on in deep stop");
  a_reset_quiet: assert property ($rose(rst_b) |-> !async_wake [*3])
    else $error("wake after reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_wake: cover property ($rose(async_wake));
  c_wait: cover property (chip_mode == 2'h1);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind ulp_suspend_resume ulp_sr_properties PROPS (.*);

// [ulp_host_model.sv]
// Purpose: host side of the usb bus, drives the line state
// Assumes: line state changes on mclk
// Notes: J is the idle level
module ulp_host_model (
  input  wire logic       mclk,
  input  wire logic [1:0] line_state,
  output logic            dplus = 1'b1,
  output logic            dminus = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk) {dplus, dminus} <= line_state;
endmodule

// [tb.sv]
// Purpose: self-checking bench for the suspend/resume block
// Assumes: host model drives the line state
// Notes: idle check runs the full 3 ms count
`include "ulp_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [1:0] er; logic [31:0] ed;} ulp_row_type;
  logic        mclk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, usb_dplus_pin_in, usb_dminus_pin_in, async_wake;
  logic        usb_dplus_pin_oe_b, usb_dminus_pin_oe_b, usb_dplus_pin_out, usb_dminus_pin_out;
  logic        usb_voltage_regulator_en, usb_clock_enable;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, chip_mode = 2'h0, line = `ULP_LS_J;
  int          failures = 0, cmp_count = 0, cyc = 0;
  ulp_row_type rows [7] = '{'{0, 4'h0, 0, 2'h0, 0}, '{1, 4'h0, 32'h25, 2'h0, 0},
    '{0, 4'h0, 0, 2'h0, 32'h25}, '{1, 4'h4, 1, 2'h2, 0}, '{0, 4'hc, 0, 2'h2, 0},
    '{0, 4'h8, 0, 2'h0, 0}, '{1, 4'h0, 32'h5, 2'h0, 0}};
  ulp_suspend_resume DUT (.*);
  ulp_host_model HOST (.mclk(mclk), .line_state(line), .dplus(usb_dplus_pin_in),
    .dminus(usb_dminus_pin_in));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw = 1, w = 1, b = 0;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge mclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge mclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !b};
    end
  endtask
  task automatic rdr(input logic [3:0] a);
    bit ar = 1, b = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!b) begin
      @(negedge mclk);
      ar = ar && !s_axi_arready;
      b = s_axi_rvalid;
      {rd, rr} = {s_axi_rdata, s_axi_rresp};
      @(posedge mclk);
      {s_axi_arvalid, s_axi_rready} <= {ar, !b};
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    chk("reset pins", 32'h64, {usb_dplus_pin_oe_b, usb_dminus_pin_oe_b, async_wake,
      usb_voltage_regulator_en, usb_clock_enable, usb_dplus_pin_out, usb_dminus_pin_out});
    @(posedge mclk) rst_b <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdr(rows[i].a);
      chk("resp", rows[i].er, rr);
      if (!rows[i].w) chk("rdata", rows[i].ed, rd);
    end
    @(negedge mclk);
    chk("pins on", 32'h1, {usb_dplus_pin_oe_b, usb_dminus_pin_oe_b, usb_voltage_regulator_en});
    $display("test registers done");
    @(posedge mclk) chip_mode <= 2'h1;
    rdr(`ULP_OFF_MODE);
    chk("wait mode", 32'h3, {rd[1:0] == 2'h1, usb_clock_enable});
    wr(`ULP_OFF_CTRL, 0);
    @(posedge mclk) chip_mode <= 2'h2;
    repeat (2) @(negedge mclk);
    chk("deep stop", 32'h6, {usb_dplus_pin_oe_b, usb_dminus_pin_oe_b, usb_clock_enable});
    @(posedge mclk) chip_mode <= 2'h0;
    wr(`ULP_OFF_CTRL, 32'h5);
    $display("test modes done");
    @(posedge mclk) line <= `ULP_LS_K;
    repeat (4) @(negedge mclk);
    chk("wake unarmed", 0, async_wake);
    @(posedge mclk) line <= `ULP_LS_J;
    repeat (59970) @(posedge mclk);
    rdr(`ULP_OFF_STATUS);
    chk("idle early", 32'h4, rd[3:0]);
    repeat (60) @(posedge mclk);
    rdr(`ULP_OFF_STATUS);
    chk("idle flag", 32'hd, rd[3:0]);
    $display("test idle done");
    wr(`ULP_OFF_CTRL, 32'h25);
    @(posedge mclk) chip_mode <= 2'h3;
    repeat (3) @(negedge mclk);
    chk("stop3 gated", 0, usb_clock_enable);
    @(posedge mclk) line <= `ULP_LS_K;
    for (int n = 0; n < 8 && async_wake !== 1'b1; n++) @(negedge mclk);
    chk("wake", 32'h3, {async_wake, usb_clock_enable});
    @(posedge mclk) {line, chip_mode} <= {`ULP_LS_J, 2'h0};
    rdr(`ULP_OFF_STATUS);
    chk("resume flag", 32'he, rd[3:0]);
    wr(`ULP_OFF_CTRL, 32'h5);
    rdr(`ULP_OFF_STATUS);
    chk("flag cleared", 32'h8, {rd[3:0], async_wake});
    $display("test resume done");
    final_report;
  end
endmodule
